// file: design/dotc_pkg.sv
// Shared constants for the on-die termination controller.
package dotc_pkg;
	// The line must reach the longest latency plus the full-burst hold.
	localparam int LINE_DEPTH = 64;
	localparam int IDX_W = 6;
	localparam logic [4:0] LAT_OFFSET = 5'h02;
	localparam logic [4:0] HOLD_CHOP = 5'h04;
	localparam logic [4:0] HOLD_FULL = 5'h06;
	localparam logic [4:0] IDX_MAX = 5'h1F;
	localparam logic [2:0] NOM_OFF = 3'h0;
	localparam logic [1:0] WR_OFF = 2'h0;
	localparam int SYNC_W = 24;
	localparam real CLK_PERIOD_NS = 25.0;
endpackage

// file: design/dotc_shift_line.sv
// Sample line that records one bit per memory clock edge.
`timescale 1ns/100ps
module dotc_shift_line
	import dotc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic shiftEn,
	input wire logic din,
	output logic [LINE_DEPTH-1:0] taps
);
	// Position n holds the sample taken n memory clock edges ago.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			taps <= '0;
		end else if (shiftEn) begin
			taps <= {taps[LINE_DEPTH-2:0], din};
		end
	end
endmodule

// file: design/dotc_ctrl.sv
// Top of the on-die termination controller: timing, strength and gating.
`timescale 1ns/100ps
module dotc_ctrl
	import dotc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic memClk,
	input wire logic termination_control_pin,
	input wire logic writeCmd,
	input wire logic burstChop,
	input wire logic dataDriving,
	input wire logic selfRefresh,
	input wire logic dllLocked,
	input wire logic prechargePowerDown,
	input wire logic mode_register_zero_dllKeep,
	input wire logic [2:0] mode_register_one_nomTerm,
	input wire logic [1:0] mode_register_two_wrTerm,
	input wire logic [4:0] cas_write_latency,
	input wire logic [4:0] additive_latency,
	output logic termOn,
	output logic termUseWrite,
	output logic [2:0] termValue,
	output logic syncMode,
	output logic asyncMode
);
	logic [SYNC_W-1:0] rawIn;
	logic [SYNC_W-1:0] meta;
	logic [SYNC_W-1:0] syncd;
	logic ckS, pinS, wrS, bcS, driveS, srS, dllS, pdS, keepS;
	logic [2:0] nomS;
	logic [1:0] wrFieldS;
	logic [4:0] casLatS, addLatS;
	logic ckPrev;
	logic ckRise;
	logic [4:0] lat;
	logic dynEn, termFieldsOn, isSync, isAsync;
	logic [LINE_DEPTH-1:0] pinLine, chopLine, fullLine;
	logic wrWindow;
	logic useWr;
	logic next_termOn;
	logic [2:0] next_termValue;

	// Tap of a sample taken base plus add memory clock edges ago; the line is deep
	// enough for the longest latency plus the full-burst hold, so nothing wraps.
	function automatic logic [IDX_W-1:0] tapIdx(input logic [4:0] base, input logic [4:0] add);
		tapIdx = {1'b0, base} + {1'b0, add};
	endfunction

	// Latency is the sum minus two, floored at zero and capped at the largest code.
	// The cap is applied after the subtraction so a large sum still lands on the top code.
	function automatic logic [4:0] latOf(input logic [4:0] casLat, input logic [4:0] addLat);
		logic [5:0] sum;
		logic [5:0] diff;
		sum = {1'b0, casLat} + {1'b0, addLat};
		diff = sum - {1'b0, LAT_OFFSET};
		if (sum < {1'b0, LAT_OFFSET}) begin
			latOf = 5'h00;
		end else if (diff > {1'b0, IDX_MAX}) begin
			latOf = IDX_MAX;
		end else begin
			latOf = diff[4:0];
		end
	endfunction

	// True while a write sampled lat to lat+len-1 edges ago is still inside its window.
	function automatic logic inWindow(input logic [LINE_DEPTH-1:0] line, input logic [4:0] base,
		input logic [4:0] len);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < int'(HOLD_FULL); k++) begin
			if (k < int'(len) && line[tapIdx(base, 5'(k))]) begin
				hit = 1'b1;
			end
		end
		inWindow = hit;
	endfunction

	// Every input comes from outside this clock's domain, so all pass two flops.
	assign rawIn = {memClk, termination_control_pin, writeCmd, burstChop, dataDriving,
		selfRefresh, dllLocked, prechargePowerDown, mode_register_zero_dllKeep,
		mode_register_one_nomTerm, mode_register_two_wrTerm, cas_write_latency,
		additive_latency};
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			syncd <= '0;
		end else begin
			meta <= rawIn;
			syncd <= meta;
		end
	end
	assign {ckS, pinS, wrS, bcS, driveS, srS, dllS, pdS, keepS, nomS, wrFieldS,
		casLatS, addLatS} = syncd;

	// Memory clock rising edges are found by sampling; the link runs far slower.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ckPrev <= 1'b0;
		end else begin
			ckPrev <= ckS;
		end
	end
	assign ckRise = ckS & ~ckPrev;

	// Latency in memory clocks; settings below the offset give zero.
	assign lat = latOf(casLatS, addLatS);
	assign isSync = dllS & ~(pdS & ~keepS);
	assign isAsync = dllS & pdS & ~keepS;
	assign dynEn = |wrFieldS;
	assign termFieldsOn = (nomS != NOM_OFF) | (wrFieldS != WR_OFF);
	// A chop write keeps write strength four edges from its tap, a full burst six.
	assign wrWindow = inWindow(chopLine, lat, HOLD_CHOP)
		| inWindow(fullLine, lat, HOLD_FULL);

	// Pin and write samples, one per memory clock edge.
	dotc_shift_line pinDelay (
		.clk(clk),
		.rst(rst),
		.shiftEn(ckRise),
		.din(pinS),
		.taps(pinLine)
	);
	dotc_shift_line chopDelay (
		.clk(clk),
		.rst(rst),
		.shiftEn(ckRise),
		.din(wrS & bcS),
		.taps(chopLine)
	);
	dotc_shift_line fullDelay (
		.clk(clk),
		.rst(rst),
		.shiftEn(ckRise),
		.din(wrS & ~bcS),
		.taps(fullLine)
	);

	// Write strength holds while any write is inside its window, so a later write
	// stretches an earlier one instead of being cut short at the older write's end.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			useWr <= 1'b0;
		end else if (!dynEn) begin
			useWr <= 1'b0;
		end else begin
			useWr <= wrWindow;
		end
	end

	// Identity helper kept so the nominal field path reads clearly.
	function automatic logic [2:0] mode_register_one_nomTermValue(input logic [2:0] f);
		mode_register_one_nomTermValue = f;
	endfunction

	// On/off decision; termination is forced off in DLL-off mode whatever the pin does.
	always_comb begin
		next_termOn = 1'b0;
		if (srS || driveS || !termFieldsOn) begin
			next_termOn = 1'b0;
		end else if (isAsync) begin
			next_termOn = pinS;
		end else if (isSync) begin
			next_termOn = pinLine[lat];
		end
	end

	// Strength select: the nominal code unless a write window is open.
	always_comb begin
		next_termValue = mode_register_one_nomTermValue(nomS);
		if (useWr && dynEn) begin
			next_termValue = {1'b0, wrFieldS};
		end
	end

	// All outputs are registered.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			termOn <= 1'b0;
			termUseWrite <= 1'b0;
			termValue <= NOM_OFF;
			syncMode <= 1'b0;
			asyncMode <= 1'b0;
		end else begin
			termOn <= next_termOn;
			termUseWrite <= useWr & dynEn;
			termValue <= next_termValue;
			syncMode <= isSync;
			asyncMode <= isAsync;
		end
	end

	chk_selfref_off: assert property (@(posedge clk) disable iff (rst)
		srS |=> !termOn) else $error("termination on during self-refresh");
	chk_drive_off: assert property (@(posedge clk) disable iff (rst)
		driveS |=> !termOn) else $error("termination on while driving");
	chk_fields_zero: assert property (@(posedge clk) disable iff (rst)
		(nomS == NOM_OFF && wrFieldS == WR_OFF) |=> !termOn)
		else $error("termination on with fields zero");
	chk_async_direct: assert property (@(posedge clk) disable iff (rst)
		(isAsync && !srS && !driveS && termFieldsOn) |=> termOn == $past(pinS))
		else $error("async termination not following pin");
	chk_pin_low_off: assert property (@(posedge clk) disable iff (rst)
		(isSync && !isAsync && !pinLine[lat]) |=> !termOn)
		else $error("sync termination on with delayed pin low");
	chk_nodyn_nominal: assert property (@(posedge clk) disable iff (rst)
		!dynEn |=> ##1 (!termUseWrite && termValue == $past(nomS)))
		else $error("write strength without dynamic mode");
	chk_wr_set: assert property (@(posedge clk) disable iff (rst)
		(dynEn && (chopLine[lat] || fullLine[lat])) |=> useWr)
		else $error("write strength not selected");
	chk_wr_clear: assert property (@(posedge clk) disable iff (rst)
		(dynEn && chopLine[tapIdx(lat, HOLD_CHOP)] && !wrWindow) |=> !useWr)
		else $error("nominal strength not restored after chop");
	chk_full_end: assert property (@(posedge clk) disable iff (rst)
		(dynEn && fullLine[tapIdx(lat, HOLD_FULL)] && !wrWindow) |=> !useWr)
		else $error("nominal strength not restored after full burst");
	chk_full_hold: assert property (@(posedge clk) disable iff (rst)
		(dynEn && fullLine[tapIdx(lat, HOLD_CHOP)]) |=> useWr)
		else $error("full burst write strength ended early");
	chk_wr_value: assert property (@(posedge clk) disable iff (rst)
		termUseWrite |-> termValue == {1'b0, $past(wrFieldS)})
		else $error("wrong write strength code");
	chk_nominal_value: assert property (@(posedge clk) disable iff (rst)
		!useWr |=> termValue == $past(nomS))
		else $error("nominal strength code not applied");
	chk_dyn_enable: assert property (@(posedge clk) disable iff (rst)
		useWr |-> $past(wrFieldS) != WR_OFF) else $error("dynamic mode not enabled");
endmodule

// file: tb/dotc_ctrl_model.sv
// Controller-side model: memory clock, termination pin and write commands.
`timescale 1ns/100ps
module dotc_ctrl_model (
	output logic memClk,
	output logic pin,
	output logic writeCmd,
	output logic burstChop,
	input logic quiet
);
	int cnt = 0;
	// Free-running memory clock; the offset keeps its edges off the system clock edges.
	initial begin
		memClk = 1'b0;
		pin = 1'b0;
		writeCmd = 1'b0;
		burstChop = 1'b0;
		#7;
		forever #100 memClk = ~memClk;
	end
	// Commands move on the falling edge so they are settled at the sampling rise.
	always @(negedge memClk) begin
		if (cnt == 0) begin
			pin = 1'($urandom % 2);
			cnt = 6 + $urandom % 4;
		end
		cnt = cnt - 1;
		// Pin held low in DLL-off mode and while the device drives read data.
		if (quiet) begin
			pin = 1'b0;
		end
		writeCmd = 1'($urandom % 2) && (cnt >= 6 || !pin);
		burstChop = 1'($urandom % 2);
	end
endmodule

// file: tb/tb.sv
// Self-checking bench for the termination controller.
`timescale 1ns/100ps
module tb;
	import dotc_pkg::*;
	logic clk = 0, rst = 1, memClk, pin, writeCmd, burstChop, keep = 1;
	logic dataDriving = 0, selfRefresh = 0, dllLocked = 1, prechargePowerDown = 0;
	logic [2:0] nom = 3'h1, termValue;
	logic [1:0] wr = 2'h1;
	logic [4:0] casLat = 5'h05, addLat = 5'h00;
	logic termOn, termUseWrite, syncMode, asyncMode;
	logic ph[0:63], wh[0:63], ch[0:63];
	int fails = 0, check_count = 0, n = 0, lat = 0, p;
	dotc_ctrl u_dotc_ctrl (.clk, .rst, .memClk, .termination_control_pin(pin), .writeCmd,
		.burstChop, .dataDriving, .selfRefresh, .dllLocked, .prechargePowerDown,
		.mode_register_zero_dllKeep(keep), .mode_register_one_nomTerm(nom),
		.mode_register_two_wrTerm(wr), .cas_write_latency(casLat), .additive_latency(addLat),
		.termOn, .termUseWrite, .termValue, .syncMode, .asyncMode);
	dotc_ctrl_model u_dotc_ctrl_model (.memClk, .pin, .writeCmd, .burstChop,
		.quiet(!dllLocked || dataDriving));
	// System clock at 40 MHz.
	initial forever #12.5 clk = ~clk;
	task check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// A write keeps the write strength from its tap until four or six edges later.
	function automatic logic expUse(int j);
		int b = j - lat;
		expUse = 1'b0;
		for (int w = 0; w <= b; w++) if (wh[w] && b - w < (ch[w] ? 4 : 6)) expUse = 1'b1;
		return expUse && wr != 2'h0;
	endfunction
	task checkEdge(int j);
		logic sy, asy, ok, u;
		sy = dllLocked && (!prechargePowerDown || keep);
		asy = dllLocked && prechargePowerDown && !keep;
		ok = !selfRefresh && !dataDriving && (nom != 3'h0 || wr != 2'h0);
		u = expUse(j);
		check(syncMode, sy);
		check(asyncMode, asy);
		if (asy && pin === ph[j]) check(termOn, ok && pin);
		if (!asy) check(termOn, sy && ok && j >= lat && ph[j - lat]);
		if (sy && ok) check(termUseWrite, u);
		if (sy && ok) check(termValue, u ? {1'b0, wr} : nom);
	endtask
	// Each memory clock rise first judges the previous edge, then records this one.
	always @(posedge memClk) begin
		if (!rst && n > 0) checkEdge(n - 1);
		if (n < 64) begin
			ph[n] = pin;
			wh[n] = writeCmd;
			ch[n] = burstChop;
		end
		n++;
	end
	task results;
		if (fails == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Watchdog well beyond the ten phases of about eight microseconds each.
	initial begin
		#300000;
		fails++;
		results;
	end
	// Each phase resets the block, so the recorded history starts from empty taps.
	initial begin
		void'($urandom(32'h6b36));
		for (p = 0; p < 10; p++) begin
			@(posedge clk);
			#1;
			rst = 1;
			{selfRefresh, dataDriving, prechargePowerDown, dllLocked, keep} = 5'h03;
			casLat = 5'h05 + 5'($urandom % 8);
			addLat = 5'($urandom % 8);
			nom = 3'h1 + 3'($urandom % 7);
			wr = 2'h1 + 2'($urandom % 3);
			case (p)
				0: {casLat, addLat} = 10'h040;
				1: {casLat, addLat} = 10'h020;
				2: {casLat, addLat} = 10'h28D;
				3: {nom, wr} = 5'h00;
				4: wr = 2'h0;
				5: selfRefresh = 1;
				6: dataDriving = 1;
				7: {prechargePowerDown, keep} = 2'h2;
				8: prechargePowerDown = 1;
				9: {dllLocked, wr} = 3'h0;
				default: ;
			endcase
			lat = int'(casLat) + int'(addLat) - 2;
			lat = lat < 0 ? 0 : (lat > 31 ? 31 : lat);
			repeat (2) @(posedge clk);
			@(negedge memClk);
			@(posedge clk);
			#1;
			rst = 0;
			// The next memory clock rise is the first edge the block records.
			n = 0;
			repeat (40) @(posedge memClk);
		end
		results;
	end
endmodule
